// ==== rtl/adcsq_defs.svh ====
// Purpose: Offsets, fields, reset values and timing counts of the ADC sequencer
// Assumes: APB word addressing, 8-bit registers in the low byte
// Notes:   Definitions only
`ifndef ADCSQ_DEFS_SVH
`define ADCSQ_DEFS_SVH

// ****************************************
// Register indices; byte address is index times 4
// ****************************************
`define ADCSQ_IDX_FLAGS    10'h00c
`define ADCSQ_IDX_RES_HI   10'h01e
`define ADCSQ_IDX_MAIN     10'h01f
`define ADCSQ_IDX_ENABLES  10'h08c
`define ADCSQ_IDX_ANALOG_PIN_SELECT    10'h091
`define ADCSQ_IDX_RES_LO   10'h09e
`define ADCSQ_IDX_CLKCFG   10'h09f
`define ADCSQ_IDX_SYSCTL   10'h0a0
`define ADCSQ_IDX_DATA     10'h0a1
`define ADCSQ_ADDR(i)      ({(i), 2'b00})

// ****************************************
// Fields
// ****************************************
`define ADCSQ_BIT_DONE     6
`define ADCSQ_BIT_JUSTIFY  7
`define ADCSQ_BIT_GO       1
`define ADCSQ_BIT_ON       0
`define ADCSQ_CLKCFG_MASK  8'h70
`define ADCSQ_MAIN_RST     8'h00
`define ADCSQ_FLAGS_RST    8'h00
`define ADCSQ_ENABLES_RST  8'h00
`define ADCSQ_ANALOG_PIN_SELECT_RST    8'hff
`define ADCSQ_CLKCFG_RST   8'h00

// ****************************************
// Timing
// ****************************************
`define ADCSQ_CONV_TICKS   4'd11
`define ADCSQ_RC_DELAY     2'd1

`endif

// ==== rtl/adcsq_pkg.sv ====
// Purpose: Types of the ADC sequencer
// Assumes: Nothing
// Notes:   Constants live in adcsq_defs.svh
package adcsq_pkg;
  typedef enum logic [1:0] {
    ADCSQ_IDLE,
    ADCSQ_WAIT_RC,
    ADCSQ_CONVERT
  } adcsq_state_type;
endpackage

// ==== rtl/adcsq_tick_gen.sv ====
// Purpose: Conversion clock tick from system divider or synchronised RC clock
// Assumes: RC oscillator is asynchronous to i_core_clk
// Notes:   One-cycle pulse per conversion clock period
`timescale 1ns/10ps
`include "adcsq_defs.svh"
module adcsq_tick_gen
(
  // Clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_arst_n,
  // Control
  input  wire logic [2:0] i_sel,
  input  wire logic       i_run,
  input  wire logic       i_rc_clk,
  // Tick
  output logic            o_tick
);
  import adcsq_pkg::*;

  logic [5:0] div_cnt_r;
  logic [5:0] div_last;
  logic [2:0] rc_sync_r;
  logic       rc_prev_r;
  logic       use_rc;

  assign use_rc = (i_sel[1:0] == 2'b11);  // [RULE3]

  always_comb
  begin
    unique case (i_sel)
      3'b000:  div_last = 6'h01;  // [RULE1]
      3'b001:  div_last = 6'h07;  // [RULE1]
      3'b010:  div_last = 6'h1f;  // [RULE1]
      3'b100:  div_last = 6'h03;  // [RULE2]
      3'b101:  div_last = 6'h0f;  // [RULE2]
      3'b110:  div_last = 6'h3f;  // [RULE2]
      default: div_last = 6'h3f;
    endcase
  end

  // Three stages; edge counts only when stages 2 and 3 agree on high
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rc_sync_r <= 3'h0;
      rc_prev_r <= 1'b0;
    end
    else
    begin
      rc_sync_r <= {rc_sync_r[1:0], i_rc_clk};
      if (rc_sync_r[2] == rc_sync_r[1])
        rc_prev_r <= rc_sync_r[2];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      div_cnt_r <= 6'h00;
    else if (!i_run || div_cnt_r >= div_last)
      div_cnt_r <= 6'h00;
    else
      div_cnt_r <= div_cnt_r + 6'h01;
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      o_tick <= 1'b0;
    else if (use_rc)  // [RULE22]
      o_tick <= i_run && rc_sync_r[2] && rc_sync_r[1] && !rc_prev_r;
    else
      o_tick <= i_run && (div_cnt_r >= div_last);  // [RULE22]
  end
endmodule

// ==== rtl/adcsq_top.sv ====
// Purpose: ADC sequencer control with APB register slave
// Assumes: 10 MHz core clock; converter core supplies 10-bit data per conversion
// Notes:   One instruction cycle is taken as one core clock
// Notes on behaviour
// RULE1 - Codes 000/001/010 divide by 2/8/32
// RULE2 - Codes 100/101/110 divide by 4/16/64
// RULE3 - Low bits 11 select internal RC clock
// RULE4 - Unimplemented clock-config bits read zero
// RULE5 - Converts in sleep only with RC clock
// RULE6 - RC clock delays start one instruction
// RULE7 - Sleep completion clears go, loads result
// RULE8 - Enabled completion in sleep wakes device
// RULE9 - Disabled completion in sleep powers off converter
// RULE10 - Sleep with non-RC clock aborts, powers off
// RULE11 - Reset restores registers and aborts conversion
// RULE12 - Reset leaves result registers unchanged
// RULE13 - Result split by justification into pair
// RULE14 - Software waits two periods before acquiring
// RULE15 - Software waits acquisition before starting
// RULE16 - Software starts with go bit, polls
// RULE17 - Software sets up flag and enables
// RULE18 - Conversion lasts eleven conversion clock periods
// RULE19 - Completion clears go, sets done flag
// RULE20 - Software clear of go aborts, keeps result
// RULE21 - Justify bit one right, zero left
// RULE22 - Ticks from divider or synchronised RC
//
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
`include "adcsq_defs.svh"
module adcsq_top
(
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_arst_n,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Converter core and system
  input  wire logic        i_rc_clk,
  input  wire logic [9:0]  i_conv_data,
  input  wire logic        i_sleep,
  output logic             o_conv_active,
  output logic [2:0]       o_channel,
  output logic [7:0]       o_analog_pins,
  output logic             o_irq,
  output logic             o_wake
);
  import adcsq_pkg::*;

  // ****************************************
  // Registers and state
  // ****************************************
  adcsq_state_type state_r;
  logic [7:0]      main_r;
  logic [7:0]      flags_r;
  logic [7:0]      enables_r;
  logic [7:0]      analog_pin_select_r;
  logic [7:0]      clkcfg_r;
  logic [7:0]      res_hi_r;
  logic [7:0]      res_lo_r;
  logic [1:0]      sysctl_r;
  logic            powered_off_r;
  logic [3:0]      tick_cnt_r;
  logic            tick;
  logic            use_rc;
  logic            acc;
  logic            wr;
  logic            go_set;
  logic            go_clr_sw;
  logic            done;
  logic            sleep_abort;
  logic            mapped;
  logic            irq_nxt;
  logic [7:0]      rd_nxt;
  logic [7:0]      wbyte;

  assign acc    = i_psel && i_penable;
  assign wr     = acc && o_pready && i_pwrite && i_pstrb[0];
  assign wbyte  = i_pwdata[7:0];
  assign use_rc = (clkcfg_r[5:4] == 2'b11);  // [RULE3]
  assign go_set = wr && (i_paddr == `ADCSQ_ADDR(`ADCSQ_IDX_MAIN)) && wbyte[`ADCSQ_BIT_GO]
                  && !main_r[`ADCSQ_BIT_GO];
  assign go_clr_sw = wr && (i_paddr == `ADCSQ_ADDR(`ADCSQ_IDX_MAIN))
                     && !wbyte[`ADCSQ_BIT_GO];
  assign done   = (state_r == ADCSQ_CONVERT) && tick
                  && (tick_cnt_r == `ADCSQ_CONV_TICKS - 4'd1);  // [RULE18]
  // Non-RC clocks have no place to run while the core clock is gated
  assign sleep_abort = i_sleep && !use_rc && (state_r != ADCSQ_IDLE);  // [RULE10] [RULE5]

  // ****************************************
  // Conversion clock ticks
  // ****************************************
  adcsq_tick_gen u_tick
  (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .i_sel      (clkcfg_r[6:4]),
    .i_run      (state_r == ADCSQ_CONVERT),
    .i_rc_clk   (i_rc_clk),
    .o_tick     (tick)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_r    <= ADCSQ_IDLE;  // [RULE11]
      tick_cnt_r <= 4'h0;
    end
    else if (sleep_abort || go_clr_sw || powered_off_r || !main_r[`ADCSQ_BIT_ON])
    begin
      state_r    <= ADCSQ_IDLE;  // [RULE20]
      tick_cnt_r <= 4'h0;
    end
    else
    begin
      unique case (state_r)
        ADCSQ_IDLE:
          if (go_set)
            state_r <= use_rc ? ADCSQ_WAIT_RC : ADCSQ_CONVERT;  // [RULE6]
        ADCSQ_WAIT_RC:
          state_r <= ADCSQ_CONVERT;  // [RULE6] [RULE5]
        ADCSQ_CONVERT:
          if (done)
            state_r <= ADCSQ_IDLE;
          else if (tick)
            tick_cnt_r <= tick_cnt_r + 4'h1;
      endcase
      if (state_r != ADCSQ_CONVERT)
        tick_cnt_r <= 4'h0;
    end
  end

  // Converter stays off after a sleep event until software rewrites the main control
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      powered_off_r <= 1'b0;  // [RULE11]
    else if (sleep_abort || (done && i_sleep && !enables_r[`ADCSQ_BIT_DONE]))
      powered_off_r <= 1'b1;  // [RULE9] [RULE10]
    else if (wr && i_paddr == `ADCSQ_ADDR(`ADCSQ_IDX_MAIN))
      powered_off_r <= 1'b0;
  end

  // ****************************************
  // Main control and configuration registers
  // ****************************************
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      main_r <= `ADCSQ_MAIN_RST;  // [RULE11]
    else
    begin
      if (wr && i_paddr == `ADCSQ_ADDR(`ADCSQ_IDX_MAIN))
        main_r <= wbyte;  // [RULE16]
      if (done || sleep_abort)
        main_r[`ADCSQ_BIT_GO] <= 1'b0;  // [RULE19] [RULE7]
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      enables_r <= `ADCSQ_ENABLES_RST;
      analog_pin_select_r   <= `ADCSQ_ANALOG_PIN_SELECT_RST;
      clkcfg_r  <= `ADCSQ_CLKCFG_RST;
      sysctl_r  <= 2'b00;
    end
    else if (wr)
    begin
      if (i_paddr == `ADCSQ_ADDR(`ADCSQ_IDX_ENABLES))
        enables_r <= wbyte;
      if (i_paddr == `ADCSQ_ADDR(`ADCSQ_IDX_ANALOG_PIN_SELECT))
        analog_pin_select_r <= wbyte;
      if (i_paddr == `ADCSQ_ADDR(`ADCSQ_IDX_CLKCFG))
        clkcfg_r <= wbyte & `ADCSQ_CLKCFG_MASK;  // [RULE4]
      if (i_paddr == `ADCSQ_ADDR(`ADCSQ_IDX_SYSCTL))
        sysctl_r <= wbyte[7:6];
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      flags_r <= `ADCSQ_FLAGS_RST;
    else if (done)
    begin
      if (wr && i_paddr == `ADCSQ_ADDR(`ADCSQ_IDX_FLAGS))
        flags_r <= wbyte;
      flags_r[`ADCSQ_BIT_DONE] <= 1'b1;  // [RULE19]
    end
    else if (wr && i_paddr == `ADCSQ_ADDR(`ADCSQ_IDX_FLAGS))
      flags_r <= wbyte;
  end

  // ****************************************
  // Result pair
  // ****************************************
  // No reset branch: contents survive device reset
  always_ff @(posedge i_core_clk)
  begin
    if (done)  // [RULE12] [RULE7] [RULE20]
    begin
      if (main_r[`ADCSQ_BIT_JUSTIFY])  // [RULE21]
      begin
        res_hi_r <= {6'h00, i_conv_data[9:8]};  // [RULE13]
        res_lo_r <= i_conv_data[7:0];
      end
      else
      begin
        res_hi_r <= i_conv_data[9:2];  // [RULE13]
        res_lo_r <= {i_conv_data[1:0], 6'h00};
      end
    end
  end

  // ****************************************
  // APB read and outputs
  // ****************************************
  always_comb
  begin
    mapped = 1'b1;
    rd_nxt = 8'h00;
    unique case (i_paddr)
      `ADCSQ_ADDR(`ADCSQ_IDX_FLAGS):   rd_nxt = flags_r;
      `ADCSQ_ADDR(`ADCSQ_IDX_RES_HI):  rd_nxt = res_hi_r;
      `ADCSQ_ADDR(`ADCSQ_IDX_MAIN):    rd_nxt = main_r;
      `ADCSQ_ADDR(`ADCSQ_IDX_ENABLES): rd_nxt = enables_r;
      `ADCSQ_ADDR(`ADCSQ_IDX_ANALOG_PIN_SELECT):   rd_nxt = analog_pin_select_r;
      `ADCSQ_ADDR(`ADCSQ_IDX_RES_LO):  rd_nxt = res_lo_r;
      `ADCSQ_ADDR(`ADCSQ_IDX_CLKCFG):  rd_nxt = clkcfg_r;  // [RULE4]
      `ADCSQ_ADDR(`ADCSQ_IDX_SYSCTL):  rd_nxt = {sysctl_r, 6'h00};
      `ADCSQ_ADDR(`ADCSQ_IDX_DATA):    rd_nxt = {6'h00, state_r != ADCSQ_IDLE, powered_off_r};
      default:                         mapped = 1'b0;
    endcase
  end

  // Zero-wait slave: pready is high in every access phase
  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_prdata  <= 32'h0000_0000;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end
    else
    begin
      o_pready  <= i_psel && !i_penable;
      o_pslverr <= i_psel && !i_penable && !mapped;
      o_prdata  <= (i_psel && !i_penable) ? {24'h00_0000, rd_nxt} : 32'h0000_0000;
    end
  end

  assign irq_nxt = flags_r[`ADCSQ_BIT_DONE] && enables_r[`ADCSQ_BIT_DONE];

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_conv_active <= 1'b0;
      o_channel     <= 3'h0;
      o_analog_pins <= `ADCSQ_ANALOG_PIN_SELECT_RST;
      o_irq         <= 1'b0;
      o_wake        <= 1'b0;
    end
    else
    begin
      o_conv_active <= (state_r == ADCSQ_CONVERT);
      o_channel     <= main_r[4:2];
      o_analog_pins <= analog_pin_select_r;
      o_irq         <= irq_nxt && sysctl_r[0] && sysctl_r[1];  // [RULE19]
      o_wake        <= done && i_sleep && enables_r[`ADCSQ_BIT_DONE];  // [RULE8]
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_done_clears_go: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    done |=> !main_r[`ADCSQ_BIT_GO] && flags_r[`ADCSQ_BIT_DONE])  // [RULE19]
    else $error("Completion did not clear go or set flag");
  a_rc_start_delay: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (state_r == ADCSQ_IDLE && go_set && use_rc && !sleep_abort && main_r[`ADCSQ_BIT_ON]
     && !powered_off_r) |=> state_r == ADCSQ_WAIT_RC)  // [RULE6]
    else $error("RC start was not delayed");
  a_sleep_abort_off: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    sleep_abort |=> state_r == ADCSQ_IDLE && powered_off_r && main_r[`ADCSQ_BIT_ON])  // [RULE10]
    else $error("Sleep abort misbehaved");
  a_abort_keeps_result: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (go_clr_sw && state_r == ADCSQ_CONVERT) |=> $stable(res_hi_r) && $stable(res_lo_r))  // [RULE20]
    else $error("Abort changed result");
  a_clkcfg_reserved: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (clkcfg_r & ~`ADCSQ_CLKCFG_MASK) == 8'h00)  // [RULE4]
    else $error("Clock config reserved bit set");
  a_right_justify: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (done && main_r[`ADCSQ_BIT_JUSTIFY]) |=> res_hi_r[7:2] == 6'h00
      && res_lo_r == $past(i_conv_data[7:0]))  // [RULE21]
    else $error("Right justified result wrong");
  a_wake_on_done: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (done && i_sleep && enables_r[`ADCSQ_BIT_DONE]) |=> o_wake)  // [RULE8]
    else $error("No wake on sleep completion");
  a_sleep_off_noirq: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (done && i_sleep && !enables_r[`ADCSQ_BIT_DONE]) |=> powered_off_r)  // [RULE9]
    else $error("Converter not powered off");
  a_div2_period: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (tick && clkcfg_r[6:4] == 3'b000 && state_r == ADCSQ_CONVERT && !done
     && !go_clr_sw && !i_sleep) |=> !tick ##1 tick)  // [RULE1]
    else $error("Divide by two period wrong");
endmodule

// ==== dv/adcsq_core_model.sv ====
// Purpose: Far side of the sequencer: RC oscillator and converter core
// Assumes: Bench sets the value the core returns before each conversion
// Notes:   Oscillator runs free, phase unrelated to the core clock
`timescale 1ns/10ps
module adcsq_core_model
(
  // Converter core side
  input  wire logic [9:0] i_value,
  output logic            o_rc_clk,
  output logic [9:0]      o_conv_data
);
  // ****
  // 500 kHz oscillator, odd offset keeps it off the core clock edges
  // ****
  initial
  begin
    o_rc_clk = 1'b0;
    #37;
    forever #1000 o_rc_clk = ~o_rc_clk;
  end
  assign o_conv_data = i_value;
endmodule

// ==== dv/adc_sequencer_control_test.sv ====
// Purpose: Self-checking bench of the sequencer against a bench-side model
// Assumes: One APB access takes setup plus one access cycle
// Notes:   RC period is 20 core clocks
`timescale 1ns/10ps
`include "adcsq_defs.svh"
module adc_sequencer_control_test;
  import adcsq_pkg::*;
  localparam logic [11:0] A_FLG = `ADCSQ_ADDR(`ADCSQ_IDX_FLAGS);
  localparam logic [11:0] A_HI  = `ADCSQ_ADDR(`ADCSQ_IDX_RES_HI);
  localparam logic [11:0] A_MN  = `ADCSQ_ADDR(`ADCSQ_IDX_MAIN);
  localparam logic [11:0] A_ENA = `ADCSQ_ADDR(`ADCSQ_IDX_ENABLES);
  localparam logic [11:0] A_ANS = `ADCSQ_ADDR(`ADCSQ_IDX_ANALOG_PIN_SELECT);
  localparam logic [11:0] A_LO  = `ADCSQ_ADDR(`ADCSQ_IDX_RES_LO);
  localparam logic [11:0] A_CLK = `ADCSQ_ADDR(`ADCSQ_IDX_CLKCFG);
  localparam logic [11:0] A_SYS = `ADCSQ_ADDR(`ADCSQ_IDX_SYSCTL);
  localparam logic [11:0] A_STA = `ADCSQ_ADDR(`ADCSQ_IDX_DATA);
  logic        clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, sleep = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [3:0]  pstrb = 4'hf;
  logic [9:0]  cval = 0, cdata;
  logic        rc_clk, pready, pslverr, act, irq, wake;
  logic [2:0]  chan;
  logic [7:0]  pins;
  int          fail_count = 0, compares = 0, hi_m, lo_m;
  bit          en = 0;

  always #50 clk = ~clk;

  adcsq_core_model u_adcsq_core_model (.i_value(cval), .o_rc_clk(rc_clk), .o_conv_data(cdata));
  adcsq_top u_adcsq_top (.i_core_clk(clk), .i_arst_n(rst_n), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_rc_clk(rc_clk), .i_conv_data(cdata),
    .i_sleep(sleep), .o_conv_active(act), .o_channel(chan), .o_analog_pins(pins),
    .o_irq(irq), .o_wake(wake));

  // ****
  // Shared tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (fail_count == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    // Only the watchdog ends a wait for pready
    do
    begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] q;
    apb(1'b1, a, d, q);
  endtask

  task automatic regs0();
    logic [11:0] ra[5] = '{A_FLG, A_MN, A_ENA, A_ANS, A_CLK};
    logic [7:0]  rv[5] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00};
    logic [7:0]  q;
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, ra[i], 8'h00, q);
      chk(q, rv[i]);
    end
    chk(pins, 8'hff);
  endtask

  // ****
  // One conversion; ab: 0 plain, 1 go cleared, 2 sleep, 3 reset, 4 sleep at go
  // ****
  task automatic conv(input logic [2:0] cs, input bit j, input int ab);
    int div, n;
    logic [7:0] q;
    logic [2:0] ch;
    bit wk, done;
    cval <= 10'($urandom);
    ch = 3'($urandom);
    div = cs[1:0] == 2'b11 ? 20 : 1 << (1 + cs[2] + 2 * cs[1:0]);
    done = ab == 0 || ab == 4;
    wr(A_CLK, {1'b1, cs, 4'hf});
    apb(1'b0, A_CLK, 8'h00, q);
    chk(q, {1'b0, cs, 4'h0});
    wr(A_MN, {j, 2'b00, ch, 2'b01});
    repeat (50) @(posedge clk);
    chk(chan, ch);
    wr(A_MN, {j, 2'b00, ch, 2'b11});
    if (ab == 4)
      sleep <= 1'b1;
    n = 0;
    wk = 0;
    while (act !== 1'b1 && n < 8)
    begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (act === 1'b1 && n < 9000)
    begin
      @(posedge clk);
      n++;
      wk |= wake;
      if (n == 5 && ab == 1)
        wr(A_MN, {j, 2'b00, ch, 2'b01});
      if (n == 5 && ab == 2)
        sleep <= 1'b1;
      if (n == 5 && ab == 3)
      begin
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
      end
    end
    repeat (3) @(posedge clk) wk |= wake;
    if (done)
    begin
      chk(n >= 10 * div && n <= 11 * div + 8, 1);
      hi_m = j ? cval >> 8 : cval >> 2;
      lo_m = j ? cval & 8'hff : (cval & 3) << 6;
    end
    else
      chk(n <= 12, 1);
    apb(1'b0, A_HI, 8'h00, q);
    chk(q, hi_m);
    apb(1'b0, A_LO, 8'h00, q);
    chk(q, lo_m);
    apb(1'b0, A_STA, 8'h00, q);
    chk(q[0], ab == 2 || (ab == 4 && !en));
    apb(1'b0, A_MN, 8'h00, q);
    chk(q[1:0], {1'b0, ab != 3});
    apb(1'b0, A_FLG, 8'h00, q);
    chk(q[6], done);
    chk(wk, ab == 4 && en);
    chk(irq, done && en);
    sleep <= 1'b0;
    wr(A_FLG, 8'h00);
    repeat (2) @(posedge clk);
    chk(irq, 0);
    repeat (2 * div) @(posedge clk);
  endtask

  // ****
  // Main sequence and watchdog
  // ****
  initial
  begin
    logic [7:0] q, pv;
    void'($urandom(32'hb443));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    regs0();
    apb(1'b0, 12'hffc, 8'h00, q);
    chk(err, 1);
    // Write without the low byte strobe must be ignored
    pstrb <= 4'he;
    wr(A_ENA, 8'h40);
    pstrb <= 4'hf;
    apb(1'b0, A_ENA, 8'h00, q);
    chk(q, 8'h00);
    pv = 8'($urandom);
    wr(A_ANS, pv);
    repeat (2) @(posedge clk);
    chk(pins, pv);
    for (int c = 0; c < 8; c++)
      conv(3'(c), c[0], 0);
    conv(3'b101, 1, 1);
    conv(3'b110, 0, 2);
    wr(A_ENA, 8'h40);
    wr(A_SYS, 8'hc0);
    en = 1;
    conv(3'b011, 1, 4);
    conv(3'b100, 0, 0);
    wr(A_ENA, 8'h00);
    en = 0;
    conv(3'b111, 0, 4);
    conv(3'b001, 1, 3);
    regs0();
    give_verdict();
  end

  // Generous bound: whole sequence is under 15000 cycles
  initial
  begin
    repeat (60000) @(posedge clk);
    fail_count++;
    give_verdict();
  end
endmodule
